// [rtl/tcr_params.svh]
/*
 * Offsets, reset values, command codes and busy times of the touch
 * controller command and output register bank.
 * Assumes it is included by bare name wherever these values are needed.
 */
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// register offsets on the serial port
`define TCR_OFS_LEVEL_READBACK 8'h00
`define TCR_OFS_LEVEL_WRITE    8'h04
`define TCR_OFS_TOUCH_EN       8'h07
`define TCR_OFS_PIN_EN         8'h08
`define TCR_OFS_STRONG         8'h11
`define TCR_OFS_TOUCH_STATE    8'h88
`define TCR_OFS_COMMAND        8'hA0

// reset values
`define TCR_RST_OUT_REGS       8'h03
`define TCR_RST_COMMAND        8'h00

// command codes
`define TCR_CMD_FW_REV         8'h00
`define TCR_CMD_STORE          8'h01
`define TCR_CMD_FACTORY        8'h02
`define TCR_CMD_WRITE_DEF      8'h03
`define TCR_CMD_READ_DEF       8'h04
`define TCR_CMD_READ_RAM       8'h05
`define TCR_CMD_RECONFIG       8'h06
`define TCR_CMD_NORMAL         8'h07
`define TCR_CMD_SETUP          8'h08
`define TCR_CMD_SCAN_START     8'h09
`define TCR_CMD_SCAN_STOP      8'h0A
`define TCR_CMD_SCAN_STATUS    8'h0B

// busy times after acknowledge, in ms
`define TCR_BUSY_NVM_MS        8'd120
`define TCR_BUSY_SHORT_MS      8'd5
`define TCR_BUSY_SCAN_MS       8'd10
`define TCR_BUSY_NONE_MS       8'd0

// system clock rate and derived cycles per ms
`define TCR_CLK_HZ             100000000
`define TCR_MS_CYCLES          (`TCR_CLK_HZ / 1000)

`endif

// [rtl/tcr_pkg.sv]
/*
 * Types of the touch controller register bank.
 * Assumes nothing of its surroundings.
 */
package tcr_pkg;

	// serial slave phases
	typedef enum logic [2:0] {
		TCR_IDLE,
		TCR_ADDR,
		TCR_ACK_ADDR,
		TCR_WRITE,
		TCR_ACK_WRITE,
		TCR_READ,
		TCR_ACK_READ
	} tcr_state_t;

endpackage

// [rtl/tcr_busy_timer.sv]
/*
 * Busy interval timer: counts whole milliseconds after a start pulse.
 * Assumes start comes as a one-cycle pulse on sys_clk.
 */
`timescale 1ns/1ns
`include "tcr_params.svh"

module tcr_busy_timer #(
	parameter int MS_CYCLES = `TCR_MS_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       start,
	input  wire logic [7:0] start_ms,
	output logic            busy
);

	logic [31:0] div_cnt;
	logic        ms_tick;
	logic [7:0]  ms_left;

	generate
		if (MS_CYCLES < 1) begin : g_bad
			$error("MS_CYCLES must be at least 1");
		end
	endgenerate

	// ms enable divider, restarted so every interval is whole
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt <= 32'h0;
			ms_tick <= 1'b0;
		end else if (start || div_cnt == 32'(MS_CYCLES - 1)) begin
			div_cnt <= 32'h0;
			ms_tick <= !start;
		end else begin
			div_cnt <= div_cnt + 32'h1;
			ms_tick <= 1'b0;
		end
	end

	// remaining ms; zero means accessible
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ms_left <= 8'h0;
		end else if (start) begin
			ms_left <= start_ms;
		end else if (ms_tick && ms_left != 8'h0) begin
			ms_left <= ms_left - 8'h1;
		end
	end

	assign busy = (ms_left != 8'h0);

endmodule

// [rtl/tcr_regs.sv]
/*
 * Command and output register bank of a touch button controller, with its
 * serial (two-wire) slave port, command decoder and output pin control.
 * Assumes scl and sda inputs synchronous to sys_clk and many clocks per bit;
 * the sensing core and nonvolatile store sit outside.
 */
//
// Contract
// RULE_01: host writes command byte to command register; code 00 gives firmware revision.
// RULE_02: code 01 saves configuration to store, then 120 ms inaccessible.
// RULE_03: codes 02 and 03 restore factory or write defaults, 120 ms inaccessible.
// RULE_04: code 04 loads defaults from store, then 5 ms inaccessible.
// RULE_05: code 05 reads working configuration, then 5 ms inaccessible.
// RULE_06: code 07 enters normal mode; code 06 reconfigures, setup mode only, 5 ms.
// RULE_07: code 08 enters setup mode, any mode, no busy time.
// RULE_08: 09 starts scan 10 ms, 0A stops 5 ms, 0B reports scan state.
// RULE_09: register 00h reads actual level of each output pin.
// RULE_10: register 04h sets pin levels except pins driven by logic operation.
// RULE_11: register 07h enables touch inputs, one bit each, reset enabled.
// RULE_12: host sets touch enables before thresholds and current source settings.
// RULE_13: register 08h enables outputs; disabled outputs float.
// RULE_14: host sets strong drive whenever it enables an output.
// RULE_15: register 11h selects strong drive, effective only on enabled outputs.
// RULE_16: registers 07h, 08h, 11h take writes only in setup mode.
// RULE_17: all other registers are writable in both modes.
// RULE_18: while busy the device does not acknowledge its address.
`timescale 1ns/1ns
`include "tcr_params.svh"

module tcr_regs #(
	parameter int         NUM_PINS  = 2,
	parameter logic [6:0] DEV_ADDR  = 7'h37,  // arbitrary neutral default
	parameter logic [7:0] FW_REV    = 8'h10,  // arbitrary neutral value
	parameter int         MS_CYCLES = `TCR_MS_CYCLES
) (
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	input  wire logic                scl,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe,
	input  wire logic [NUM_PINS-1:0] pin_level_bits,
	input  wire logic [NUM_PINS-1:0] logic_combine_select,
	input  wire logic [NUM_PINS-1:0] logic_combine_value,
	input  wire logic [7:0]          touch_state,
	output logic [NUM_PINS-1:0]      digital_output_bits,
	output logic [NUM_PINS-1:0]      output_pin_enable_alias,
	output logic [NUM_PINS-1:0]      drive_strength_bits,
	output logic [NUM_PINS-1:0]      touch_enable,
	output logic                     setup_mode,
	output logic                     scan_running,
	output logic                     store_req,
	output logic [7:0]               store_op,
	output logic                     busy
);

	tcr_pkg::tcr_state_t state;
	logic [7:0]          shift;
	logic [3:0]          bit_cnt;
	logic [7:0]          ptr;
	logic                ptr_phase;
	logic                read_dir;
	logic                scl_q;
	logic                sda_q;
	logic                scl_d;
	logic                sda_d;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_cond;
	logic                stop_cond;
	logic                wr_en;
	logic                cmd_en;
	logic [7:0]          output_level_write;
	logic [7:0]          touch_input_enable;
	logic [7:0]          output_pin_enable;
	logic [7:0]          output_strong_drive;
	logic [7:0]          reply;
	logic                busy_start;
	logic [7:0]          busy_ms;
	logic [7:0]          rd_word;

	generate
		if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_bad
			$error("NUM_PINS must be 1 to 8");
		end
	endgenerate
	// registers only setup mode may change
	function automatic logic setup_only(input logic [7:0] addr);
		return addr == `TCR_OFS_TOUCH_EN || addr == `TCR_OFS_PIN_EN || addr == `TCR_OFS_STRONG;
	endfunction
	// read mux; write-only registers read their held value
	function automatic logic [7:0] read_value(input logic [7:0] addr);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			// RULE_09: pin level readback
			`TCR_OFS_LEVEL_READBACK: v = 8'(pin_level_bits);
			`TCR_OFS_LEVEL_WRITE:    v = output_level_write;
			`TCR_OFS_TOUCH_EN:       v = touch_input_enable;
			`TCR_OFS_PIN_EN:         v = output_pin_enable;
			`TCR_OFS_STRONG:         v = output_strong_drive;
			`TCR_OFS_TOUCH_STATE:    v = touch_state;
			`TCR_OFS_COMMAND:        v = reply;
			default:                 v = 8'h00;
		endcase
		return v;
	endfunction
	// word at the pointer; a function result cannot be bit-selected directly
	always_comb rd_word = read_value(ptr);

	// two register stages; inputs are already synchronous
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{scl_d, sda_d, scl_q, sda_q} <= 4'hF;
		end else begin
			{scl_d, sda_d, scl_q, sda_q} <= {scl_q, sda_q, scl, sda_in};
		end
	end

	assign scl_rise   = scl_q && !scl_d;
	assign scl_fall   = !scl_q && scl_d;
	assign start_cond = scl_q && scl_d && !sda_q && sda_d;
	assign stop_cond  = scl_q && scl_d && sda_q && !sda_d;
	assign sda_out    = 1'b0; // open drain: only the enable moves
	// data byte taken at end of its acknowledge
	assign wr_en  = state == tcr_pkg::TCR_ACK_WRITE && scl_fall && !ptr_phase && !busy;
	assign cmd_en = wr_en && ptr == `TCR_OFS_COMMAND;
	// serial slave sequencer; sda driven low only, open drain
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state     <= tcr_pkg::TCR_IDLE;
			shift     <= 8'h00;
			bit_cnt   <= 4'h0;
			ptr       <= 8'h00;
			ptr_phase <= 1'b0;
			read_dir  <= 1'b0;
			sda_oe    <= 1'b0;
		end else if (stop_cond) begin
			state  <= tcr_pkg::TCR_IDLE;
			sda_oe <= 1'b0;
		end else if (start_cond) begin
			state   <= tcr_pkg::TCR_ADDR;
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
		end else begin
			case (state)
				tcr_pkg::TCR_ADDR, tcr_pkg::TCR_WRITE: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], sda_q};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						if (state == tcr_pkg::TCR_WRITE) begin
							state  <= tcr_pkg::TCR_ACK_WRITE;
							sda_oe <= 1'b1;
						// RULE_18: no acknowledge while busy
						end else if (shift[7:1] == DEV_ADDR && !busy) begin
							state    <= tcr_pkg::TCR_ACK_ADDR;
							read_dir <= shift[0];
							sda_oe   <= 1'b1;
						end else
							state <= tcr_pkg::TCR_IDLE;
					end
				end
				tcr_pkg::TCR_ACK_ADDR: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (read_dir) begin
							state  <= tcr_pkg::TCR_READ;
							shift  <= rd_word;
							ptr    <= ptr + 8'h1;
							sda_oe <= !rd_word[7];
						end else begin
							state     <= tcr_pkg::TCR_WRITE;
							ptr_phase <= 1'b1;
							sda_oe    <= 1'b0;
						end
					end
				end
				tcr_pkg::TCR_ACK_WRITE: begin
					if (scl_fall) begin
						state     <= tcr_pkg::TCR_WRITE;
						bit_cnt   <= 4'h0;
						sda_oe    <= 1'b0;
						ptr_phase <= 1'b0;
						ptr       <= ptr_phase ? shift : ptr + 8'h1; // first byte is the pointer
					end
				end
				tcr_pkg::TCR_READ: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h7) begin
							state  <= tcr_pkg::TCR_ACK_READ;
							sda_oe <= 1'b0;
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
							shift   <= {shift[6:0], 1'b0};
							sda_oe  <= !shift[6];
						end
					end
				end
				tcr_pkg::TCR_ACK_READ: begin
					if (scl_rise) begin
						read_dir <= !sda_q; // master ack keeps reading
					end else if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (read_dir) begin
							state  <= tcr_pkg::TCR_READ;
							shift  <= rd_word;
							ptr    <= ptr + 8'h1;
							sda_oe <= !rd_word[7];
						end else
							state <= tcr_pkg::TCR_IDLE;
					end
				end
				default: state <= tcr_pkg::TCR_IDLE;
			endcase
		end
	end

	// mode and scan flags
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			setup_mode   <= 1'b0;
			scan_running <= 1'b1;
		end else if (cmd_en) begin
			case (shift)
				// RULE_06: back to normal mode
				`TCR_CMD_NORMAL:     setup_mode <= 1'b0;
				// RULE_07: setup mode from either mode
				`TCR_CMD_SETUP:      setup_mode <= 1'b1;
				// RULE_08: scan start and stop
				`TCR_CMD_SCAN_START: scan_running <= 1'b1;
				`TCR_CMD_SCAN_STOP:  scan_running <= 1'b0;
				// RULE_06: reconfigure returns to power-on mode
				`TCR_CMD_RECONFIG:   if (setup_mode) setup_mode <= 1'b0;
				default:             scan_running <= scan_running;
			endcase
		end
	end

	// busy time per command, counted from end of acknowledge
	always_comb begin
		busy_start = cmd_en;
		busy_ms    = `TCR_BUSY_NONE_MS;
		case (shift)
			// RULE_02 RULE_03: store-class commands, 120 ms
			`TCR_CMD_STORE, `TCR_CMD_FACTORY, `TCR_CMD_WRITE_DEF: busy_ms = `TCR_BUSY_NVM_MS;
			// RULE_04 RULE_05 RULE_08: loads and scan stop, 5 ms
			`TCR_CMD_READ_DEF, `TCR_CMD_READ_RAM, `TCR_CMD_SCAN_STOP: busy_ms = `TCR_BUSY_SHORT_MS;
			// RULE_06: reconfigure busy only when executed
			`TCR_CMD_RECONFIG: busy_ms = setup_mode ? `TCR_BUSY_SHORT_MS : `TCR_BUSY_NONE_MS;
			// RULE_08: scan start, 10 ms
			`TCR_CMD_SCAN_START: busy_ms = `TCR_BUSY_SCAN_MS;
			default: busy_ms = `TCR_BUSY_NONE_MS;
		endcase
	end

	// command reply and store requests
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reply     <= `TCR_RST_COMMAND;
			store_req <= 1'b0;
			store_op  <= `TCR_RST_COMMAND;
		end else begin
			store_req <= 1'b0;
			if (cmd_en) begin
				// RULE_01: revision returned at once
				if (shift == `TCR_CMD_FW_REV) begin
					reply <= FW_REV;
				end else if (shift == `TCR_CMD_SCAN_STATUS) begin
					reply <= {7'h00, scan_running};
				end
				// store traffic only for 01..05 and 06 in setup mode
				if ((shift >= `TCR_CMD_STORE && shift <= `TCR_CMD_READ_RAM) ||
				    (shift == `TCR_CMD_RECONFIG && setup_mode)) begin
					store_req <= 1'b1;
					store_op  <= shift;
				end
			end
		end
	end

	// output and enable registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			output_level_write  <= `TCR_RST_OUT_REGS;
			touch_input_enable  <= `TCR_RST_OUT_REGS;
			output_pin_enable   <= `TCR_RST_OUT_REGS;
			output_strong_drive <= `TCR_RST_OUT_REGS;
		end else if (cmd_en && (shift == `TCR_CMD_FACTORY || (shift == `TCR_CMD_RECONFIG && setup_mode))) begin
			// restore defaults locally; the store refills the rest
			touch_input_enable  <= `TCR_RST_OUT_REGS;
			output_pin_enable   <= `TCR_RST_OUT_REGS;
			output_strong_drive <= `TCR_RST_OUT_REGS;
			output_level_write  <= `TCR_RST_OUT_REGS;
		// RULE_16: setup-only writes gated by mode
		// RULE_17: other registers writable in any mode
		end else if (wr_en && (!setup_only(ptr) || setup_mode)) begin
			case (ptr)
				`TCR_OFS_LEVEL_WRITE: output_level_write  <= shift;
				// RULE_11: touch input enables
				`TCR_OFS_TOUCH_EN:    touch_input_enable  <= shift;
				`TCR_OFS_PIN_EN:      output_pin_enable   <= shift;
				`TCR_OFS_STRONG:      output_strong_drive <= shift;
				default:              output_level_write  <= output_level_write;
			endcase
		end
	end

	// pin drive, registered per pin
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					digital_output_bits[gi]     <= 1'b1;
					output_pin_enable_alias[gi] <= 1'b1;
					drive_strength_bits[gi]     <= 1'b1;
					touch_enable[gi]            <= 1'b1;
				end else begin
					// RULE_10: logic-operation pins ignore port writes
					digital_output_bits[gi]     <= logic_combine_select[gi] ? logic_combine_value[gi]
					                                                       : output_level_write[gi];
					// RULE_13: disabled output floats
					output_pin_enable_alias[gi] <= output_pin_enable[gi];
					// RULE_15: strong drive only on enabled output
					drive_strength_bits[gi]     <= output_strong_drive[gi] && output_pin_enable[gi];
					touch_enable[gi]            <= touch_input_enable[gi];
				end
			end
		end
	endgenerate

	// busy interval timer, started only by timed commands
	tcr_busy_timer #(.MS_CYCLES(MS_CYCLES)) u_busy (.sys_clk(sys_clk), .sys_rst(sys_rst), .busy(busy),
		.start(busy_start && busy_ms != `TCR_BUSY_NONE_MS), .start_ms(busy_ms));

endmodule

// [bench/tcr_regs_chk.sv]
/* Port checker for the touch register bank.
   Assumes binding to tcr_regs, one clock and an async high reset. */
`timescale 1ns/1ns
module tcr_regs_chk #(
	parameter int NUM_PINS  = 2,
	parameter int MS_CYCLES = 100000
) (
	input wire logic                sys_clk,
	input wire logic                sys_rst,
	input wire logic                scl,
	input wire logic                sda_in,
	input wire logic                sda_oe,
	input wire logic [NUM_PINS-1:0] output_pin_enable_alias,
	input wire logic [NUM_PINS-1:0] drive_strength_bits,
	input wire logic [NUM_PINS-1:0] touch_enable,
	input wire logic                setup_mode,
	input wire logic                scan_running,
	input wire logic                store_req,
	input wire logic [7:0]          store_op,
	input wire logic                busy
);
	int   busy_len;
	logic start_busy;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// length of the running busy interval, cleared when idle
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			busy_len <= 0;
		else
			busy_len <= busy ? busy_len + 1 : 0;
	end
	// start seen mid-interval; the slave must stay off the line until idle
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			start_busy <= 1'b0;
		else
			start_busy <= busy && (start_busy || (scl && $fell(sda_in)));
	end

	chk_busy_length: assert property ($fell(busy) |-> busy_len inside
		{5*MS_CYCLES, 5*MS_CYCLES+1, 10*MS_CYCLES, 10*MS_CYCLES+1, 120*MS_CYCLES, 120*MS_CYCLES+1})
		else $error("busy interval of unexpected length");
	chk_busy_no_ack: assert property (start_busy |-> !sda_oe)
		else $error("address answered while busy");
	chk_store_pulse: assert property (store_req |-> store_op inside {[8'h01:8'h06]} ##1 !store_req)
		else $error("bad store request");
	chk_store_busy: assert property (store_req |-> ##[0:2] busy)
		else $error("store request without busy interval");
	chk_setup_no_busy: assert property ($rose(setup_mode) |-> !busy [*3])
		else $error("setup entry raised busy");
	chk_scan_busy: assert property ($changed(scan_running) |-> ##[0:2] busy)
		else $error("scan change without busy interval");
	chk_locked_regs: assert property (!setup_mode && !$past(setup_mode) |->
		(($past(touch_enable) & ~touch_enable) == '0) && (($past(output_pin_enable_alias) & ~output_pin_enable_alias) == '0))
		else $error("setup register cleared in normal mode");
	chk_strong_masked: assert property ($stable(output_pin_enable_alias) |->
		(drive_strength_bits & ~output_pin_enable_alias) == '0)
		else $error("strong drive on a disabled pin");
endmodule

bind tcr_regs tcr_regs_chk #(.NUM_PINS(NUM_PINS), .MS_CYCLES(MS_CYCLES)) u_chk (.sys_clk, .sys_rst, .scl,
	.sda_in, .sda_oe, .output_pin_enable_alias, .drive_strength_bits, .touch_enable, .setup_mode,
	.scan_running, .store_req, .store_op, .busy);

// [bench/tcr_host.sv]
/* Host model on the two-wire port: drives scl, pulls sda low.
   Assumes a pull-up resolves sda outside; steps on sys_clk falls. */
`timescale 1ns/1ns
module tcr_host #(
	parameter int HALF = 10
) (
	input  wire logic sys_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// bus idle, both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// one third of a bit; slow enough for the slave's input pipe
	task automatic gap();
		repeat (HALF) @(negedge sys_clk);
	endtask
	task automatic start();
		sda_low = 1'b0;
		gap();
		scl = 1'b1;
		gap();
		sda_low = 1'b1;
		gap();
		scl = 1'b0;
		gap();
	endtask
	// stop: sda released while scl high
	task automatic stop();
		sda_low = 1'b1;
		gap();
		scl = 1'b1;
		gap();
		sda_low = 1'b0;
		gap();
	endtask
	// sda moves only with scl low, read back at scl high
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		gap();
		scl = 1'b1;
		gap();
		r = sda;
		scl = 1'b0;
		gap();
	endtask
	// msb first, ninth bit is the acknowledge
	task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic nack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(mack, nack);
	endtask
endmodule

// [bench/tb_tcr_regs.sv]
/* Self-checking bench for the touch register bank over its two-wire port.
   Assumes tcr_regs, tcr_host and the bound checker are compiled first. */
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_tcr_regs;
	localparam int         MS   = 80;
	localparam logic [6:0] ADDR = 7'h37;
	localparam logic [7:0] REV  = 8'h5C; // arbitrary revision value
	logic       sys_clk, sys_rst, scl, sda_low, sda_in, sda_out, sda_oe, nack;
	logic       setup_mode, scan_running, store_req, busy;
	logic [1:0] pin_level_bits, logic_combine_select, logic_combine_value, digital_output_bits;
	logic [1:0] output_pin_enable_alias, drive_strength_bits, touch_enable;
	logic [7:0] touch_state, store_op, rdat;
	int         err_count, checks, cycles, busy_cnt;
	logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h06, 8'h07, 8'h0A, 8'h09, 8'h0B};
	int         ms [12]    = '{0, 120, 120, 120, 5, 5, 0, 5, 0, 5, 10, 0};

	// open drain with pull-up
	assign sda_in = !(sda_low || sda_oe);
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	tcr_host h (.sys_clk, .sda(sda_in), .scl, .sda_low);
	tcr_regs #(.NUM_PINS(2), .DEV_ADDR(ADDR), .FW_REV(REV), .MS_CYCLES(MS)) DUT (.sys_clk, .sys_rst, .scl,
		.sda_in, .sda_out, .sda_oe, .pin_level_bits, .logic_combine_select, .logic_combine_value,
		.touch_state, .digital_output_bits, .output_pin_enable_alias, .drive_strength_bits, .touch_enable,
		.setup_mode, .scan_running, .store_req, .store_op, .busy);

	// closing report, reached from the sequence or the ceiling
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// cycle ceiling well above the expected run; busy length meter
	always @(posedge sys_clk) begin
		cycles++;
		if (busy === 1'b1)
			busy_cnt++;
		if (cycles == 95000) begin
			err_count++;
			print_verdict();
		end
	end
	// register write: pointer byte then one data byte
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic [7:0] q;
		logic       n;
		h.start();
		h.byte_io({ADDR, 1'b0}, 1'b1, q, n);
		`CHK(n, 1'b0)
		h.byte_io(ofs, 1'b1, q, n);
		h.byte_io(d, 1'b1, q, n);
		h.stop();
	endtask
	// register read via repeated start, one byte closed by a nack
	task automatic rc(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] q;
		logic       n;
		h.start();
		h.byte_io({ADDR, 1'b0}, 1'b1, q, n);
		h.byte_io(ofs, 1'b1, q, n);
		h.start();
		h.byte_io({ADDR, 1'b1}, 1'b1, q, n);
		h.byte_io(8'hFF, 1'b1, q, n);
		h.stop();
		`CHK(q, exp)
	endtask

	// main sequence
	initial begin
		sys_rst = 1'b1;
		pin_level_bits = 2'b10;
		logic_combine_select = 2'b10;
		logic_combine_value = 2'b11;
		touch_state = 8'h5A;
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		rc(8'h00, 8'h02);
		rc(8'h07, 8'h03);
		rc(8'h08, 8'h03);
		rc(8'h11, 8'h03);
		rc(8'h88, 8'h5A);
		rc(8'h30, 8'h00);
		wr(8'h07, 8'h00);
		wr(8'h08, 8'h00);
		rc(8'h07, 8'h03);
		`CHK(output_pin_enable_alias, 2'b11)
		$display("test reset and lock done");
		wr(8'hA0, 8'h08);
		wr(8'h07, 8'h02);
		`CHK(touch_enable, 2'b10)
		// strong drive set with the enable
		wr(8'h08, 8'h01);
		wr(8'h11, 8'h03);
		`CHK(output_pin_enable_alias, 2'b01)
		`CHK(drive_strength_bits, 2'b01)
		wr(8'h04, 8'h00);
		`CHK(digital_output_bits, 2'b10)
		pin_level_bits = 2'b01;
		rc(8'h00, 8'h01);
		$display("test setup registers done");
		for (int i = 0; i < 12; i++) begin
			busy_cnt = 0;
			wr(8'hA0, codes[i]);
			if (ms[i] != 0) begin
				h.start();
				h.byte_io({ADDR, 1'b0}, 1'b1, rdat, nack);
				h.stop();
				`CHK(nack, 1'b1)
			end
			for (int k = 0; k < 12000 && busy !== 1'b0; k++)
				@(negedge sys_clk);
			`CHK(busy_cnt == ms[i] * MS || busy_cnt == ms[i] * MS + 1, 1'b1)
			if (codes[i] inside {[8'h01:8'h06]})
				`CHK(store_op, codes[i])
			case (codes[i])
				8'h00: rc(8'hA0, REV);
				8'h08: `CHK(setup_mode, 1'b1)
				8'h06: `CHK(setup_mode, 1'b0)
				8'h0A: `CHK(scan_running, 1'b0)
				8'h0B: rc(8'hA0, 8'h01);
				default: ;
			endcase
		end
		$display("test commands done");
		logic_combine_select = 2'b00;
		wr(8'h04, 8'h02);
		`CHK(digital_output_bits, 2'b10)
		`CHK(touch_enable, 2'b11)
		// reconfigure outside setup mode must be ignored
		wr(8'hA0, 8'h06);
		`CHK(busy, 1'b0)
		$display("test normal mode writes done");
		print_verdict();
	end
endmodule
